// >>> rtl/hcw_master.v
// half-duplex control-word serial master with transmit and receive fifos
// assumes pins pass through pads; serial_in_pin comes from another domain
// Contract
// R1: send 8-bit control word, capture nothing meanwhile
// R2: slave waits one clock, returns 4-16 bits
// R3: idle: clock low, select high, data low
// R4: fifo write starts frame, load on select fall
// R5: select low, slave tristated during control word
// R6: slave latches control bits on rising clock
// R7: slave drives response on falling clock
// R8: sample response on rising clock
// R9: single: select high one period later, store word
// R10: slave releases line after lsb or select
// R11: continuous: select stays low, frames back to back
// R12: next control byte right after received lsb
// R13: continuous: store word on falling edge after lsb
// R14: role fixed as master, no switching
// R15: transmit disabled: data output high impedance
// R16: response width 4 to 16, msb first
// R17: start when enabled with fifo data
// R18: clock pulses only inside active frames
`timescale 1ns/1ps
`include "hcw_defines.vh"

module hcw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clock,
    input  wire             rst_b,
    input  wire             clk_en,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    integer         i;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_q];
    assign push      = clk_en & in_valid & in_ready;
    assign pop       = clk_en & out_valid & out_ready;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q        <= wr_q + 1'b1;
            end
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

module hcw_master (
    input  wire        clock,
    input  wire        rst_b,
    input  wire        clk_en,
    input  wire        port_enable,
    input  wire        tx_enable,
    input  wire        continuous,
    input  wire [4:0]  resp_bits,
    input  wire        tx_valid,
    output wire        tx_ready,
    input  wire [7:0]  tx_data,
    output wire        rx_valid,
    input  wire        rx_ready,
    output wire [15:0] rx_data,
    output wire        busy,
    output reg         serial_clock_pin,
    output reg         frame_select_pin,
    output reg         serial_out_pin,
    output wire        serial_out_oe_b,
    input  wire        serial_in_pin
);
    // role is master only; no slave logic exists (R14)
    reg  [2:0]  st_q;
    reg  [7:0]  div_q;
    reg  [4:0]  bit_q;
    reg  [7:0]  tsh_q;
    reg  [15:0] rsh_q;
    reg  [4:0]  len_q;
    reg         din_s1_q;
    reg         din_s2_q;
    reg         wr_q;
    reg  [15:0] wd_q;
    wire        tf_valid;
    wire [7:0]  tf_data;
    wire        tf_pop;
    wire        rf_ready;
    wire        half;
    wire        rise;
    wire        fall;
    wire [4:0]  len_w;

    function [4:0] clamp_len;
        input [4:0] b;
        begin
            if (b < `HCW_RESP_MIN)
                clamp_len = `HCW_RESP_MIN;
            else if (b > `HCW_RESP_MAX)
                clamp_len = `HCW_RESP_MAX;
            else
                clamp_len = b;
        end
    endfunction

    assign len_w           = clamp_len(resp_bits); // R16
    assign half            = (div_q == `HCW_SCK_HALF - 8'h01);
    assign rise            = half & ~serial_clock_pin;
    assign fall            = half & serial_clock_pin;
    assign busy            = (st_q != `HCW_ST_IDLE);
    assign serial_out_oe_b = ~tx_enable; // R15
    // R4 R17: pop at select fall, or after lsb if continuous, when enabled with fifo data and rx room
    assign tf_pop = clk_en & port_enable & tf_valid & rf_ready & half
                  & ((st_q == `HCW_ST_IDLE)
                  | (st_q == `HCW_ST_RESP & fall & bit_q == 5'h01 & continuous));

    hcw_fifo #(.WIDTH(8), .DEPTH(`HCW_FIFO_DEPTH), .AW(`HCW_FIFO_AW)) u_txf (
        .clock     (clock),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (tf_valid),
        .out_ready (tf_pop),
        .out_data  (tf_data)
    );

    hcw_fifo #(.WIDTH(16), .DEPTH(`HCW_FIFO_DEPTH), .AW(`HCW_FIFO_AW)) u_rxf (
        .clock     (clock),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (wr_q),
        .in_ready  (rf_ready),
        .in_data   (wd_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
        end else if (clk_en) begin
            din_s1_q <= serial_in_pin;
            din_s2_q <= din_s1_q;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q             <= `HCW_ST_IDLE;
            div_q            <= 8'h00;
            bit_q            <= 5'h00;
            tsh_q            <= 8'h00;
            rsh_q            <= 16'h0000;
            len_q            <= `HCW_RESP_MIN;
            wr_q             <= 1'b0;
            wd_q             <= 16'h0000;
            serial_clock_pin <= 1'b0;
            frame_select_pin <= 1'b1;
            serial_out_pin   <= 1'b0;
        end else if (clk_en) begin
            wr_q  <= 1'b0;
            div_q <= half ? 8'h00 : div_q + 8'h01;
            if (half) begin
                case (st_q)
                `HCW_ST_IDLE: begin
                    serial_clock_pin <= 1'b0; // R3 R18
                    frame_select_pin <= 1'b1; // R3
                    serial_out_pin   <= 1'b0; // R3
                    if (tf_pop) begin
                        frame_select_pin <= 1'b0; // R4
                        tsh_q            <= tf_data;
                        serial_out_pin   <= tf_data[7];
                        len_q            <= len_w;
                        bit_q            <= `HCW_CTRL_BITS;
                        st_q             <= `HCW_ST_SETUP;
                    end
                end
                `HCW_ST_SETUP: begin
                    serial_clock_pin <= 1'b1; // first rising edge
                    st_q             <= `HCW_ST_CTRL;
                end
                `HCW_ST_CTRL: begin
                    serial_clock_pin <= ~serial_clock_pin;
                    if (fall) begin
                        // no capture while control word leaves (R1 R5)
                        bit_q <= bit_q - 5'h01;
                        if (bit_q == 5'h01) begin
                            serial_out_pin <= 1'b0;
                            st_q           <= `HCW_ST_WAIT;
                        end else begin
                            tsh_q          <= {tsh_q[6:0], 1'b0};
                            serial_out_pin <= tsh_q[6]; // R1
                        end
                    end
                end
                `HCW_ST_WAIT: begin
                    // one clock for the slave to decode (R2)
                    serial_clock_pin <= ~serial_clock_pin;
                    if (fall) begin
                        // cleared so short words come out right-justified (R16)
                        rsh_q <= 16'h0000;
                        bit_q <= len_q;
                        st_q  <= `HCW_ST_RESP;
                    end
                end
                `HCW_ST_RESP: begin
                    serial_clock_pin <= ~serial_clock_pin;
                    if (rise)
                        rsh_q <= {rsh_q[14:0], din_s2_q}; // R8 R16
                    if (fall) begin
                        bit_q <= bit_q - 5'h01;
                        if (bit_q == 5'h01) begin
                            if (tf_pop) begin
                                // back to back, select held low (R11 R12 R13)
                                wr_q           <= 1'b1;
                                wd_q           <= rsh_q;
                                tsh_q          <= tf_data;
                                serial_out_pin <= tf_data[7];
                                len_q          <= len_w;
                                bit_q          <= `HCW_CTRL_BITS;
                                st_q           <= `HCW_ST_CTRL;
                            end else
                                st_q <= `HCW_ST_TAIL;
                        end
                    end
                end
                `HCW_ST_TAIL: begin
                    // one period after lsb, then select rises (R9 R18)
                    serial_clock_pin <= 1'b0;
                    frame_select_pin <= 1'b1; // R9
                    wr_q             <= 1'b1;
                    wd_q             <= rsh_q;
                    st_q             <= `HCW_ST_IDLE;
                end
                default: st_q <= `HCW_ST_IDLE;
                endcase
            end
        end
    end
endmodule

// >>> rtl/hcw_defines.vh
// constants for the half-duplex control-word serial master
// assumes inclusion by rtl files only
`ifndef HCW_DEFINES_VH
`define HCW_DEFINES_VH
`define HCW_CTRL_BITS     5'h08
`define HCW_RESP_MIN      5'h04
`define HCW_RESP_MAX      5'h10
`define HCW_FIFO_DEPTH    8
`define HCW_FIFO_AW       3
`define HCW_SCK_HALF      8'h04
`define HCW_ST_IDLE       3'h0
`define HCW_ST_SETUP      3'h1
`define HCW_ST_CTRL       3'h2
`define HCW_ST_WAIT       3'h3
`define HCW_ST_RESP       3'h4
`define HCW_ST_TAIL       3'h5
`endif

// >>> sim/hcw_master_properties.sv
// pin timing checks for the serial master
// assumes clk_en high and resp_bits steady per run
`timescale 1ns/1ps
module hcw_master_props (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       tx_enable,
    input wire logic [4:0] resp_bits,
    input wire logic       busy,
    input wire logic       rx_valid,
    input wire logic       serial_clock_pin,
    input wire logic       frame_select_pin,
    input wire logic       serial_out_pin,
    input wire logic       serial_out_oe_b
);
    int rise_cnt_q;
    always @(posedge clock or negedge rst_b)
        if (!rst_b) rise_cnt_q <= 0;
        else if ($fell(frame_select_pin)) rise_cnt_q <= 0;
        else if ($rose(serial_clock_pin)) rise_cnt_q <= rise_cnt_q + 1;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_idle; frame_select_pin |-> !serial_clock_pin && !serial_out_pin; endproperty
    a_idle: assert property (p_idle) else $error("idle pins wrong");
    property p_clk_frame; serial_clock_pin |-> !frame_select_pin && busy; endproperty
    a_clk_frame: assert property (p_clk_frame) else $error("clock outside frame");
    property p_oe; !tx_enable && !$past(tx_enable) |-> serial_out_oe_b; endproperty
    a_oe: assert property (p_oe) else $error("data driven while off");
    property p_start; $fell(frame_select_pin) |-> !serial_clock_pin[*4] ##1 serial_clock_pin;
    endproperty
    a_start: assert property (p_start) else $error("first clock misplaced");
    property p_half; $rose(serial_clock_pin) |-> serial_clock_pin[*4] ##1 !serial_clock_pin;
    endproperty
    a_half: assert property (p_half) else $error("clock high time wrong");
    property p_chg; $changed(serial_out_pin) && !frame_select_pin && !$past(frame_select_pin)
        |-> $fell(serial_clock_pin); endproperty
    a_chg: assert property (p_chg) else $error("data moved off falling clock");
    property p_count; $rose(frame_select_pin) |-> rise_cnt_q % (9 + resp_bits) == 0; endproperty
    a_count: assert property (p_count) else $error("clock count per frame wrong");
    property p_store; $rose(frame_select_pin) |-> ##[0:3] rx_valid; endproperty
    a_store: assert property (p_store) else $error("word not stored");
endmodule
bind hcw_master hcw_master_props u_props (.clock, .rst_b, .tx_enable, .resp_bits, .busy,
    .rx_valid, .serial_clock_pin, .frame_select_pin, .serial_out_pin, .serial_out_oe_b);

// >>> sim/hcw_slave_model.sv
// serial slave answering control words
// assumes clock idles low, select active low
`timescale 1ns/1ps
module hcw_slave_model (
    input  wire logic       sclk,
    input  wire logic       sel_b,
    input  wire logic       sdo,
    input  wire logic [4:0] nbits,
    input  wire logic       slow,
    output logic            sdi
);
    int          pos;
    logic [7:0]  ctl;
    logic [15:0] rsp;
    initial begin
        pos = 0;
        sdi = 1'b0;
    end
    always @(negedge sel_b) pos = 0;
    always @(posedge sel_b) sdi = ~sdi;
    always @(posedge sclk) begin
        if (!sel_b && pos < 8) ctl = {ctl[6:0], sdo};
        pos = (pos + 1) % (9 + nbits);
    end
    always @(negedge sclk) begin
        #(slow ? 8 : 1);
        rsp = {~ctl, ctl};
        if (pos >= 9 && pos < 9 + nbits) sdi = rsp[8 + nbits - pos];
        else sdi = ~sdi;
    end
endmodule

// >>> sim/tb_top.sv
// bench for the serial master against a slave model
// assumes 200 MHz clock
`timescale 1ns/1ps
module tb_top;
    logic        clock, rst_b, clk_en, port_enable, tx_enable, continuous, slow;
    logic        tx_valid, tx_ready, rx_valid, rx_ready, busy, serial_in_pin;
    logic        serial_clock_pin, frame_select_pin, serial_out_pin, serial_out_oe_b;
    logic [4:0]  resp_bits;
    logic [7:0]  tx_data;
    logic [15:0] rx_data;
    int          mismatches, checks_done, sel_rises;
    int          exp_q[$];
    hcw_master dut (.clock, .rst_b, .clk_en, .port_enable, .tx_enable, .continuous,
        .resp_bits, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .busy,
        .serial_clock_pin, .frame_select_pin, .serial_out_pin, .serial_out_oe_b,
        .serial_in_pin);
    hcw_slave_model slave (.sclk(serial_clock_pin), .sel_b(frame_select_pin),
        .sdo(serial_out_pin), .nbits(resp_bits), .slow, .sdi(serial_in_pin));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge frame_select_pin) sel_rises++;
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic run(input int nfr, input logic cont, input logic [4:0] n);
        logic [7:0] b;
        int         idle;
        port_enable = 1'b0;
        continuous = cont;
        resp_bits = n;
        slow = 1'($urandom_range(1));
        sel_rises = 0;
        for (int i = 0; i < nfr; i++) begin
            b = 8'($urandom);
            tx_data = b;
            tx_valid = 1'b1;
            for (int t = 0; t < 50 && tx_ready !== 1'b1; t++) @(negedge clock);
            if (tx_ready !== 1'b1) begin
                mismatches++;
                $display("ERROR %0t tx fifo never ready", $time);
                results;
            end
            @(negedge clock);
            exp_q.push_back({~b, b} & ((1 << n) - 1));
        end
        tx_valid = 1'b0;
        if (nfr == 8) check(tx_ready, 1'b0, "full fifo accepts");
        check(frame_select_pin, 1'b1, "frame before enable");
        port_enable = 1'b1;
        idle = 0;
        for (int i = 0; i < 20000 && idle < 40; i++) begin
            @(negedge clock);
            idle = (busy === 1'b0) ? idle + 1 : 0;
        end
        if (idle < 40) begin
            mismatches++;
            $display("ERROR %0t frames hung", $time);
            results;
        end
        check(16'(sel_rises), cont ? 16'h0001 : 16'(nfr), "select rises");
        rx_ready = 1'b1;
        while (exp_q.size() > 0) begin
            for (int t = 0; t < 50 && rx_valid !== 1'b1; t++) @(negedge clock);
            if (rx_valid !== 1'b1) begin
                mismatches++;
                $display("ERROR %0t response word missing", $time);
                results;
            end
            check(rx_data, 16'(exp_q.pop_front()), "response word");
            @(negedge clock);
        end
        rx_ready = 1'b0;
        @(negedge clock);
        check(rx_valid, 1'b0, "extra word");
    endtask
    initial begin
        {rst_b, port_enable, continuous, tx_valid, rx_ready, slow} = '0;
        clk_en = 1'b1;
        tx_enable = 1'b1;
        resp_bits = 5'h04;
        tx_data = 8'h00;
        mismatches = 0;
        checks_done = 0;
        void'($urandom(94));
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        check({serial_clock_pin, frame_select_pin, serial_out_pin, serial_out_oe_b},
            4'h4, "idle pins");
        run(8, 1'b0, 5'h04);
        run(4, 1'b1, 5'h10);
        run(3, 1'b0, 5'($urandom_range(16, 4)));
        run(2, 1'b1, 5'($urandom_range(16, 4)));
        tx_enable = 1'b0;
        @(negedge clock);
        check(serial_out_oe_b, 1'b1, "data line driven");
        results;
    end
endmodule
